// *** hdl/ita_top.v ***
// Indirect access unit: learned table readout, wake-event registers, filter rules
// Contract
// - Learned table is read only to host
// - Readout bit 71 flags empty, resets 1
// - Bits 70:61 give valid entries minus one
// - Bits 60:59 report two-bit aging counter
// - Bits 58:56 encode learning port
// - Bit 55 high until entry ready
// - Nine data bytes 112..120, MSB first
// - Address register write triggers table read
// - Space 100 selects wake-event registers
// - Address byte picks byte of 32-bit register
// - Global bit 1 enables wake output
// - Global bit 0 sets wake polarity
// - Event status bits latch, write-one clears
// - Mask bits gate events onto wake output
// - Four ports, sixteen rules each
// - Port number forms address bits 11:8
// - Rule bytes 0x00..0x0d, MSB first
// - 0x10/0x11 byte enables, 0x12 control
// - Space 010 selects filter rules
`timescale 1ns/10ps
`include "ita_consts.vh"
module ita_top (
  input wire mclk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_rvalid_out,
  output reg tbl_req_out,
  output reg [9:0] tbl_idx_out,
  input wire tbl_ack_in,
  input wire tbl_vacant_in,
  input wire [9:0] tbl_count_in,
  input wire [1:0] tbl_age_in,
  input wire [1:0] tbl_port_in,
  input wire [6:0] tbl_filter_group_id_in,
  input wire [47:0] tbl_station_in,
  input wire magic_det_in,
  input wire link_up_det_in,
  input wire energy_det_in,
  output reg wake_event_output_out,
  output reg wake_event_oe_n_out
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RD = 2'b01;
  localparam ST_WR = 2'b10;

  // Encode the learning port into the readout field
  function [2:0] src_code;
    input [1:0] p;
    begin
      case (p)
        2'd0: src_code = `ITA_SRC_P1;
        2'd1: src_code = `ITA_SRC_P2;
        2'd2: src_code = `ITA_SRC_P3;
        default: src_code = `ITA_SRC_P4;
      endcase
    end
  endfunction

  // Byte of a 32-bit register, offset 0 is the top byte
  function [7:0] pick32;
    input [31:0] v;
    input [1:0] off;
    begin
      case (off)
        2'd0: pick32 = v[31:24];
        2'd1: pick32 = v[23:16];
        2'd2: pick32 = v[15:8];
        default: pick32 = v[7:0];
      endcase
    end
  endfunction

  reg [7:0] ctrl_r;
  reg [7:0] addr_r;
  reg [7:0] byte_r;
  reg [71:0] entry_r;
  reg busy_r;
  reg [1:0] gctl_r;
  reg [2:0] status_r;
  reg [2:0] mask_r [1:3];
  reg [111:0] stage_r;
  reg [15:0] ben_r;
  reg [3:0] rule_entry_r;
  reg [1:0] rule_port_r;
  reg [1:0] state_r;
  reg [3:0] cnt_r;
  reg [1:0] state_nxt;
  reg [3:0] cnt_nxt;

  wire [2:0] space = ctrl_r[`ITA_CTRL_SPACE];
  wire is_read = ctrl_r[`ITA_CTRL_READ];
  wire [3:0] port_n = ctrl_r[`ITA_CTRL_PORT];
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `ITA_REG_CTRL);
  wire wr_addr = reg_wr_in && (reg_addr_in == `ITA_REG_ADDR);
  wire wr_byte = reg_wr_in && (reg_addr_in == `ITA_REG_BYTE);
  wire [7:0] data_idx = reg_addr_in - `ITA_REG_DATA_FIRST;
  wire wake_sel = (space == `ITA_SPACE_WAKE) && (port_n <= `ITA_WAKE_PORTS) && (addr_r <= `ITA_WAKE_LAST_OFF);
  wire rule_sel = (space == `ITA_SPACE_RULE) && (port_n != 4'h0) && (port_n <= `ITA_RULE_PORTS);
  wire [1:0] rule_port = port_n[1:0] - 2'd1;

  // Value of the wake-event register byte at the current offset
  reg [7:0] wake_byte;
  reg [31:0] wake_word;
  always @* begin
    wake_word = 32'h0;
    if (port_n == 4'h0) begin
      wake_word = {30'h0, gctl_r};
    end else if (addr_r[`ITA_WAKE_MASK_BIT]) begin
      wake_word = {29'h0, mask_r[port_n[1:0]]};
    end else begin
      wake_word = {29'h0, status_r};
    end
    wake_byte = pick32(wake_word, addr_r[1:0]);
  end

  // Value of the filter rule byte at the current offset
  reg [7:0] rule_byte;
  always @* begin
    rule_byte = 8'h00;
    if (addr_r <= {4'h0, `ITA_RULE_LAST_BYTE}) begin
      rule_byte = stage_r[8'd111 - {addr_r[3:0], 3'b000} -: 8];
    end else if (addr_r == `ITA_RULE_BE_HI) begin
      rule_byte = ben_r[15:8];
    end else if (addr_r == `ITA_RULE_BE_LO) begin
      rule_byte = ben_r[7:0];
    end else if (addr_r == `ITA_RULE_CSR) begin
      rule_byte = {(state_r != ST_IDLE), 3'h0, rule_entry_r};
    end
  end

  // Index register and control register
  always @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_r <= `ITA_CTRL_RESET;
      addr_r <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata_in;
      end
      if (wr_addr) begin
        addr_r <= reg_wdata_in;
      end
    end
  end

  // Learned-table readout: request on trigger, hold not-ready until answer
  wire tbl_trigger = wr_addr && (space == `ITA_SPACE_TABLE) && is_read &&
                     (ctrl_r[`ITA_CTRL_TBL] == `ITA_TBL_DYNAMIC);
  always @(posedge mclk_in) begin
    if (rst_in) begin
      entry_r <= `ITA_ENTRY_RESET;
      busy_r <= 1'b0;
      tbl_req_out <= 1'b0;
      tbl_idx_out <= 10'h000;
    end else begin
      tbl_req_out <= tbl_trigger;
      if (tbl_trigger) begin
        tbl_idx_out <= {ctrl_r[`ITA_CTRL_IDX_HI], reg_wdata_in};
        busy_r <= 1'b1;
      end else if (tbl_ack_in && busy_r) begin
        busy_r <= 1'b0;
        entry_r[`ITA_BIT_VACANT] <= tbl_vacant_in;
        entry_r[70:61] <= tbl_count_in;
        entry_r[60:59] <= tbl_age_in;
        entry_r[58:56] <= src_code(tbl_port_in);
        entry_r[54:48] <= tbl_filter_group_id_in;
        entry_r[47:0] <= tbl_station_in;
      end
    end
  end

  wire [71:0] readout = {entry_r[71:56], busy_r, entry_r[54:0]};

  // Wake-event registers; a new event wins over a clear in the same cycle
  wire wake_wr = wr_byte && wake_sel && !is_read;
  wire [2:0] events = {magic_det_in, link_up_det_in, energy_det_in};
  wire low_byte = (addr_r[1:0] == 2'd3);
  integer i;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      gctl_r <= 2'b00;
      status_r <= 3'b000;
      for (i = 1; i <= `ITA_WAKE_PORTS; i = i + 1) begin
        mask_r[i] <= 3'b000;
      end
    end else begin
      if (wake_wr && low_byte && (port_n == 4'h0) && !addr_r[`ITA_WAKE_MASK_BIT]) begin
        gctl_r <= reg_wdata_in[1:0];
      end
      if (wake_wr && low_byte && (port_n != 4'h0) && addr_r[`ITA_WAKE_MASK_BIT]) begin
        mask_r[port_n[1:0]] <= reg_wdata_in[2:0];
      end
      if (wake_wr && low_byte && (port_n != 4'h0) && !addr_r[`ITA_WAKE_MASK_BIT]) begin
        status_r <= (status_r & ~reg_wdata_in[2:0]) | events;
      end else begin
        status_r <= status_r | events;
      end
    end
  end

  // Pending enabled events drive the wake pin
  wire [2:0] any_mask = mask_r[1] | mask_r[2] | mask_r[3];
  wire wake_pending = |(status_r & any_mask);
  always @(posedge mclk_in) begin
    if (rst_in) begin
      wake_event_output_out <= 1'b1;
      wake_event_oe_n_out <= 1'b1;
    end else begin
      wake_event_oe_n_out <= ~gctl_r[`ITA_GC_EN];
      if (gctl_r[`ITA_GC_EN] && wake_pending) begin
        wake_event_output_out <= gctl_r[`ITA_GC_POL];
      end else begin
        wake_event_output_out <= ~gctl_r[`ITA_GC_POL];
      end
    end
  end

  // Filter rule staging, byte enables and transfer sequencer
  wire rule_wr = wr_byte && rule_sel && !is_read;
  wire rule_go = rule_wr && (addr_r == `ITA_RULE_CSR) && (state_r == ST_IDLE);
  wire [7:0] mem_rdata;
  wire [9:0] mem_addr = {rule_port_r, rule_entry_r, cnt_r};
  wire mem_we = (state_r == ST_WR) && ben_r[4'hf - cnt_r];
  wire [7:0] mem_wdata = stage_r[8'd111 - {cnt_r, 3'b000} -: 8];

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 4'h0;
        if (rule_go) begin
          state_nxt = reg_wdata_in[`ITA_RULE_CSR_READ] ? ST_RD : ST_WR;
        end
      end
      ST_RD: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == `ITA_RULE_BYTES) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WR: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == `ITA_RULE_LAST_BYTE) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 4'h0;
      end
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      stage_r <= 112'h0;
      ben_r <= 16'h0000;
      rule_entry_r <= 4'h0;
      rule_port_r <= 2'b00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (rule_go) begin
        rule_entry_r <= reg_wdata_in[`ITA_RULE_CSR_ENTRY];
        rule_port_r <= rule_port;
      end
      if (state_r == ST_RD && cnt_r != 4'h0) begin
        stage_r[8'd111 - {cnt_r - 4'h1, 3'b000} -: 8] <= mem_rdata;
      end else if (rule_wr && state_r == ST_IDLE && addr_r <= {4'h0, `ITA_RULE_LAST_BYTE}) begin
        stage_r[8'd111 - {addr_r[3:0], 3'b000} -: 8] <= reg_wdata_in;
      end
      if (rule_wr && addr_r == `ITA_RULE_BE_HI) begin
        ben_r[15:8] <= reg_wdata_in;
      end
      if (rule_wr && addr_r == `ITA_RULE_BE_LO) begin
        ben_r[7:0] <= reg_wdata_in;
      end
    end
  end

  ita_mem u_mem (
    .mclk_in(mclk_in),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  // Indirect byte register loads on a read trigger
  always @(posedge mclk_in) begin
    if (rst_in) begin
      byte_r <= 8'h00;
    end else if (wr_addr && is_read) begin
      if (space == `ITA_SPACE_WAKE && port_n <= `ITA_WAKE_PORTS && reg_wdata_in <= `ITA_WAKE_LAST_OFF) begin
        byte_r <= pick32(port_n == 4'h0 ? {30'h0, gctl_r} :
                         (reg_wdata_in[`ITA_WAKE_MASK_BIT] ? {29'h0, mask_r[port_n[1:0]]} : {29'h0, status_r}),
                         reg_wdata_in[1:0]);
      end else begin
        byte_r <= 8'h00;
      end
    end else if (reg_rd_in && reg_addr_in == `ITA_REG_BYTE && is_read) begin
      byte_r <= wake_sel ? wake_byte : (rule_sel ? rule_byte : 8'h00);
    end
  end

  // Host read answer, one cycle after the strobe
  always @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        if (reg_addr_in == `ITA_REG_CTRL) begin
          reg_rdata_out <= ctrl_r;
        end else if (reg_addr_in == `ITA_REG_ADDR) begin
          reg_rdata_out <= addr_r;
        end else if (reg_addr_in >= `ITA_REG_DATA_FIRST && reg_addr_in <= `ITA_REG_DATA_LAST) begin
          reg_rdata_out <= readout[8'd71 - {data_idx[4:0], 3'b000} -: 8];
        end else if (reg_addr_in == `ITA_REG_BYTE) begin
          if (wake_sel) begin
            reg_rdata_out <= wake_byte;
          end else if (rule_sel) begin
            reg_rdata_out <= rule_byte;
          end else begin
            reg_rdata_out <= byte_r;
          end
        end else begin
          reg_rdata_out <= 8'h00;
        end
      end
    end
  end
endmodule

// *** pkg/ita_consts.vh ***
// Constants of the indirect table access unit
`ifndef ITA_CONSTS_VH
`define ITA_CONSTS_VH
`define ITA_REG_CTRL 8'h6e
`define ITA_REG_ADDR 8'h6f
`define ITA_REG_DATA_FIRST 8'h70
`define ITA_REG_DATA_LAST 8'h78
`define ITA_REG_BYTE 8'ha0
`define ITA_SPACE_TABLE 3'h0
`define ITA_SPACE_RULE 3'h2
`define ITA_SPACE_WAKE 3'h4
`define ITA_TBL_DYNAMIC 2'h2
`define ITA_CTRL_SPACE 7:5
`define ITA_CTRL_READ 4
`define ITA_CTRL_TBL 3:2
`define ITA_CTRL_IDX_HI 1:0
`define ITA_CTRL_PORT 3:0
`define ITA_CTRL_RESET 8'h00
`define ITA_ENTRY_RESET 72'h800000000000000000
`define ITA_BIT_VACANT 71
`define ITA_BIT_NOT_READY 55
`define ITA_SRC_P1 3'h0
`define ITA_SRC_P2 3'h1
`define ITA_SRC_P3 3'h2
`define ITA_SRC_P4 3'h4
`define ITA_GC_EN 1
`define ITA_GC_POL 0
`define ITA_EV_MAGIC 2
`define ITA_EV_LINK 1
`define ITA_EV_ENERGY 0
`define ITA_WAKE_PORTS 3
`define ITA_WAKE_LAST_OFF 8'h07
`define ITA_WAKE_MASK_BIT 2
`define ITA_RULE_LAST_BYTE 4'hd
`define ITA_RULE_BYTES 4'he
`define ITA_RULE_BE_HI 8'h10
`define ITA_RULE_BE_LO 8'h11
`define ITA_RULE_CSR 8'h12
`define ITA_RULE_PORTS 4'h4
`define ITA_RULE_CSR_BUSY 7
`define ITA_RULE_CSR_READ 4
`define ITA_RULE_CSR_ENTRY 3:0
`define ITA_MEM_AW 10
`endif

// *** hdl/ita_mem.v ***
// Byte memory holding the per-port filter rule lists
`timescale 1ns/10ps
module ita_mem (
  input wire mclk_in,
  input wire we_in,
  input wire [9:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out
);
  reg [7:0] mem_r [0:1023];

  always @(posedge mclk_in) begin
    if (we_in) begin
      mem_r[addr_in] <= wdata_in;
    end
    rdata_out <= mem_r[addr_in];
  end
endmodule

// *** testbench/ita_sva.sv ***
// Assertion checker for the indirect table access unit
`timescale 1ns/10ps
module ita_sva (
  input wire mclk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_rvalid_out,
  input wire tbl_req_out,
  input wire [9:0] tbl_idx_out,
  input wire tbl_ack_in,
  input wire [47:0] tbl_station_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  reg [7:0] ctrl_r;
  reg pend_r;
  reg fresh_r;
  reg seen_r;
  reg [7:0] stn_r;
  wire rd72 = reg_rd_in && reg_addr_in == 8'h72;
  wire trig = reg_wr_in && reg_addr_in == 8'h6f;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_r <= 8'h00;
      pend_r <= 1'b0;
      fresh_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h6e) ctrl_r <= reg_wdata_in;
      if (tbl_ack_in) stn_r <= tbl_station_in[7:0];
      pend_r <= (pend_r | tbl_req_out) & ~tbl_ack_in;
      fresh_r <= tbl_ack_in | (fresh_r & ~tbl_req_out);
      seen_r <= seen_r | tbl_ack_in;
    end
  end
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("answer without read");
  a_rdata_hold: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("read data moved");
  a_fetch_start: assert property (trig && ctrl_r[7:2] == 6'h06 |=>
    tbl_req_out && tbl_idx_out == {ctrl_r[1:0], $past(reg_wdata_in)}) else $error("bad fetch");
  a_fetch_cause: assert property (tbl_req_out |-> $past(trig))
    else $error("fetch without trigger");
  a_idx_steady: assert property (!tbl_req_out |-> $stable(tbl_idx_out))
    else $error("index moved");
  a_not_ready: assert property ((pend_r || tbl_req_out) && !tbl_ack_in && rd72 |=> reg_rdata_out[7])
    else $error("ready too early");
  a_ready_after: assert property (fresh_r && !tbl_req_out && rd72 |=> !reg_rdata_out[7])
    else $error("ready missing");
  a_station_low: assert property (fresh_r && reg_rd_in && reg_addr_in == 8'h78 |=> reg_rdata_out == stn_r)
    else $error("station byte wrong");
  a_vacant_reset: assert property (!seen_r && reg_rd_in && reg_addr_in == 8'h70 |=> reg_rdata_out == 8'h80)
    else $error("vacant flag wrong");
  c_ack: cover property (tbl_ack_in);
  c_wait: cover property (pend_r && rd72);
  c_trig: cover property (trig && ctrl_r[7:2] == 6'h06);
endmodule

// *** testbench/ita_tbl_model.sv ***
// Learned table model answering fetches after a set delay
`timescale 1ns/10ps
module ita_tbl_model (
  input wire mclk_in,
  input wire rst_in,
  input wire req_in,
  input wire [9:0] idx_in,
  input wire [3:0] delay_in,
  output reg ack_out,
  output wire [69:0] fields_out
);
  reg [9:0] idx_r;
  reg [4:0] cnt_r;
  // Fields only hold with the ack; otherwise inverted garbage
  wire [69:0] v = {&idx_r, idx_r, idx_r[1:0], idx_r[9:8], idx_r[6:0], {4{idx_r, 2'h1}}};
  assign fields_out = ack_out ? v : ~v;
  always @(posedge mclk_in) begin
    ack_out <= 1'b0;
    if (rst_in) begin
      cnt_r <= 5'h00;
      idx_r <= 10'h000;
    end else if (req_in) begin
      idx_r <= idx_in;
      cnt_r <= {1'b0, delay_in} + 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
      ack_out <= cnt_r == 5'h01;
    end
  end
endmodule

// *** testbench/indirect_table_access_bench.sv ***
// Testbench for the indirect table access unit
`timescale 1ns/10ps
module indirect_table_access_bench;
  reg mclk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [7:0] reg_addr_in = 8'h00;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg [7:0] reg_wdata_in = 8'h00;
  reg [2:0] ev = 3'h0;
  reg [3:0] dly = 4'h0;
  wire [7:0] rdo;
  wire rv, req, ack, pin, oe_n;
  wire [9:0] idx;
  wire [69:0] f;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer cyc = 0;
  reg [15:0] expq[$];
  reg [15:0] ent;
  reg [7:0] last;
  always #2 mclk_in = ~mclk_in;
  ita_top i_ita_top (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdo), .reg_rvalid_out(rv),
    .tbl_req_out(req), .tbl_idx_out(idx), .tbl_ack_in(ack), .tbl_vacant_in(f[69]), .tbl_count_in(f[68:59]),
    .tbl_age_in(f[58:57]), .tbl_port_in(f[56:55]), .tbl_filter_group_id_in(f[54:48]),
    .tbl_station_in(f[47:0]), .magic_det_in(ev[2]), .link_up_det_in(ev[1]), .energy_det_in(ev[0]),
    .wake_event_output_out(pin), .wake_event_oe_n_out(oe_n));
  ita_tbl_model i_ita_tbl_model (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req), .idx_in(idx),
    .delay_in(dly), .ack_out(ack), .fields_out(f));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      @(negedge mclk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      expq.push_back({m, e});
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      @(posedge mclk_in);
    end
  endtask
  task pulse(input [2:0] b);
    begin
      @(negedge mclk_in);
      ev = b;
      @(negedge mclk_in);
      ev = 3'h0;
      repeat (3) @(negedge mclk_in);
    end
  endtask
  task print_verdict;
    begin
      $display("Compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  function [71:0] ent_of(input [9:0] x);
    ent_of = {&x, x, x[1:0], x[9:8] == 2'h3 ? 3'h4 : {1'b0, x[9:8]}, 1'b0, x[6:0], {4{x, 2'h1}}};
  endfunction
  // Result monitor: pairs each answer with the oldest noted expectation
  always @(negedge mclk_in) begin
    if (rv === 1'b1) begin
      last = rdo;
      if (expq.size() == 0) begin
        check(8'hff, 8'h00);
      end else begin
        ent = expq.pop_front();
        if (ent[15:8] != 8'h00) check(rdo & ent[15:8], ent[7:0]);
      end
    end
  end
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  initial begin : main
    reg [9:0] x;
    reg [71:0] e;
    reg [7:0] d;
    integer i;
    integer k;
    integer n;
    n = $urandom(4574);
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    rd(8'h70, 8'hff, 8'h80);
    rd(8'h71, 8'hff, 8'h00);
    @(negedge mclk_in);
    check({6'h0, oe_n, pin}, 8'h03);
    $display("Test reset readout done");
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      x = {i[1:0], i == 3 ? 8'hff : d};
      dly = $urandom % 7;
      e = ent_of(x);
      wr(8'h6e, {6'h06, x[9:8]});
      wr(8'h70, 8'h55);
      wr(8'h6f, x[7:0]);
      n = 0;
      last = 8'h80;
      while (last[7] && n < 40) begin
        rd(8'h72, 8'h00, 8'h00);
        n = n + 1;
      end
      for (k = 0; k < 9; k = k + 1)
        rd(8'h70 + k[7:0], 8'hff, e[71 - 8 * k -: 8]);
    end
    $display("Test learned table done");
    wr(8'h6e, 8'h80);
    wr(8'h6f, 8'h03);
    wr(8'ha0, 8'h03);
    wr(8'h6e, 8'h90);
    wr(8'h6f, 8'h03);
    rd(8'ha0, 8'hff, 8'h03);
    wr(8'h6f, 8'h00);
    rd(8'ha0, 8'hff, 8'h00);
    @(negedge mclk_in);
    check({7'h0, oe_n}, 8'h00);
    check({7'h0, pin}, 8'h00);
    wr(8'h6e, 8'h81);
    wr(8'h6f, 8'h07);
    wr(8'ha0, 8'h01);
    pulse(3'h2);
    check({7'h0, pin}, 8'h00);
    pulse(3'h1);
    check({7'h0, pin}, 8'h01);
    pulse(3'h4);
    wr(8'h6e, 8'h91);
    wr(8'h6f, 8'h03);
    rd(8'ha0, 8'hff, 8'h07);
    wr(8'h6e, 8'h81);
    wr(8'ha0, 8'h01);
    repeat (3) @(negedge mclk_in);
    check({7'h0, pin}, 8'h00);
    wr(8'h6e, 8'h91);
    rd(8'ha0, 8'hff, 8'h06);
    // Active-low pin: idle high, then low once link-up is enabled
    wr(8'h6e, 8'h80);
    wr(8'h6f, 8'h03);
    wr(8'ha0, 8'h02);
    repeat (3) @(negedge mclk_in);
    check({7'h0, pin}, 8'h01);
    wr(8'h6e, 8'h81);
    wr(8'h6f, 8'h07);
    wr(8'ha0, 8'h03);
    repeat (3) @(negedge mclk_in);
    check({7'h0, pin}, 8'h00);
    $display("Test wake events done");
    for (i = 1; i < 5; i = i + 1) begin
      for (k = 0; k < 14; k = k + 13) begin
        d = $urandom;
        wr(8'h6e, {4'h4, i[3:0]});
        wr(8'h6f, k[7:0]);
        wr(8'ha0, d);
        wr(8'h6e, {4'h5, i[3:0]});
        wr(8'h6f, k[7:0]);
        rd(8'ha0, 8'hff, d);
      end
    end
    wr(8'h6f, 8'h0e);
    rd(8'ha0, 8'hff, 8'h00);
    // Store a full entry through the csr, spoil staging, fetch it back
    wr(8'h6e, 8'h43);
    for (k = 0; k < 14; k = k + 1) begin
      wr(8'h6f, k[7:0]);
      wr(8'ha0, 8'h30 + k[7:0]);
    end
    wr(8'h6f, 8'h10);
    wr(8'ha0, 8'hff);
    wr(8'h6f, 8'h11);
    wr(8'ha0, 8'hfc);
    wr(8'h6f, 8'h12);
    wr(8'ha0, 8'h05);
    wr(8'h6e, 8'h53);
    rd(8'ha0, 8'h8f, 8'h85);
    repeat (16) @(negedge mclk_in);
    rd(8'ha0, 8'hff, 8'h05);
    wr(8'h6e, 8'h43);
    for (k = 0; k < 14; k = k + 13) begin
      wr(8'h6f, k[7:0]);
      wr(8'ha0, 8'h00);
    end
    wr(8'h6f, 8'h12);
    wr(8'ha0, 8'h15);
    wr(8'h6e, 8'h53);
    repeat (16) @(negedge mclk_in);
    for (k = 0; k < 14; k = k + 1) begin
      wr(8'h6f, k[7:0]);
      rd(8'ha0, 8'hff, 8'h30 + k[7:0]);
    end
    $display("Test filter rules done");
    print_verdict;
  end
endmodule
bind ita_top ita_sva i_ita_sva (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .tbl_req_out(tbl_req_out), .tbl_idx_out(tbl_idx_out),
  .tbl_ack_in(tbl_ack_in), .tbl_station_in(tbl_station_in));
